// ==== pkg/wdt_pkg.sv ====
// Constants for the watchdog and standby control block.
// Assumes a single 200 MHz clock and an active-low asynchronous reset.
package wdt_pkg;
  // Watchdog mode register field positions.
  localparam int MODE_RUN_BIT = 7; // Start/clear bit.
  localparam int MODE_PRIO_BIT = 4; // Watchdog over non-maskable priority.
  localparam int MODE_RSV3_BIT = 3; // Software writes zero here.
  localparam int MODE_DIV_LO = 1; // Count clock select, low bit.
  localparam int MODE_DIV_HI = 2; // Count clock select, high bit.
  localparam logic [7:0] MODE_WMASK = 8'h9e; // Bits 6, 5 and 0 are held at zero.
  localparam logic [7:0] MODE_RESET = 8'h00; // Reset value of the mode register.
  // Standby control register fields.
  localparam int SBY_STOP_BIT = 1; // Stop request.
  localparam int SBY_HALT_BIT = 0; // Halt request.
  localparam int SBY_ORIGIN_BIT = 2; // Standby origin flag.
  localparam logic [7:0] SBY_RESET = 8'h00; // Reset value.
  // Count clock divider and watchdog count widths.
  localparam int DIV_W = 12;            // Prescaler width.
  localparam int CNT_W = 8;             // Watchdog count width.
  localparam int IRQ_N = 8;             // Interrupt sources watched by standby.
  // Prescaler taps for the four count clock selections.
  localparam int TAP0 = 5;
  localparam int TAP1 = 7;
  localparam int TAP2 = 9;
  localparam int TAP3 = 11;
endpackage

// ==== rtl/prescaler.sv ====
// Free-running divider that supplies the watchdog count clock tick.
// Assumes ref_clk and an active-low asynchronous reset nrst.
`timescale 1ns/1ps
module prescaler
  import wdt_pkg::*;
(
  input wire logic ref_clk,         // System clock.
  input wire logic nrst,            // Asynchronous reset, active low.
  input wire logic [1:0] sel,       // Count clock selection.
  output logic tick                 // One-cycle count clock pulse.
);
  typedef struct packed {
    logic [DIV_W-1:0] div;          // Divider value.
    logic tap_d;                    // Previous level of the chosen tap.
  } pre_state_t;
  pre_state_t st_r;                 // Current state.
  pre_state_t st_nxt;               // Next state.
  logic tap;                        // Selected tap level.

  ////////////////////////////////////////////////////////////////////////////
  // The divider clears only on reset, so a watchdog clear leaves its phase alone.
  always_comb begin
    case (sel)
      2'h0: tap = st_r.div[TAP0];
      2'h1: tap = st_r.div[TAP1];
      2'h2: tap = st_r.div[TAP2];
      default: tap = st_r.div[TAP3];
    endcase
    st_nxt = st_r;
    st_nxt.div = st_r.div + {{(DIV_W-1){1'b0}}, 1'b1};
    st_nxt.tap_d = tap;
    tick = tap & ~st_r.tap_d;
  end

  // Registers the divider state.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ==== rtl/watchdog_standby_control.sv ====
// Watchdog timer with its interrupt priority and the standby entry logic.
// Assumes the CPU core decodes the immediate store and reports its events.
// Once started, the watchdog can only be cleared; only a reset stops it.
`timescale 1ns/1ps
module watchdog_standby_control
  import wdt_pkg::*;
(
  input wire logic ref_clk,                // System clock, 200 MHz.
  input wire logic nrst,                   // Asynchronous reset, active low.
  input wire logic mode_imm_we,            // Immediate-store write strobe.
  input wire logic mode_plain_we,          // Ordinary store aimed at mode register.
  input wire logic [7:0] wdata,            // Write data.
  input wire logic standby_control_we,                // Standby control write strobe.
  input wire logic [IRQ_N-1:0] irq_flag,   // Interrupt request flags.
  input wire logic [IRQ_N-1:0] irq_mask,   // Interrupt mask flags.
  input wire logic [IRQ_N-1:0] irq_svc_sel, // Service select flags.
  input wire logic macro_busy,             // Macro service in progress.
  input wire logic nmi_req,                // Non-maskable request.
  input wire logic insn_done,              // Instruction completed pulse.
  input wire logic wake,                   // Standby release event.
  output logic [7:0] watchdog_mode,        // Mode register readback.
  output logic [7:0] standby_control,      // Standby register readback.
  output logic watchdog_interrupt,         // Watchdog interrupt to the CPU.
  output logic nmi_take,                   // Non-maskable vector request.
  output logic halted,                     // Processor held in halt.
  output logic stopped                     // Processor held in stop.
);
  typedef enum logic [1:0] {
    SB_RUN = 2'b00,                        // Executing.
    SB_WAIT = 2'b01,                       // Waiting for macro service.
    SB_HALT = 2'b10,                       // Halted.
    SB_STOP = 2'b11                        // Stopped.
  } sb_state_t;

  typedef struct packed {
    logic [7:0] mode;                      // Watchdog mode register.
    logic origin;                          // Standby origin flag.
    logic [CNT_W-1:0] cnt;                 // Watchdog count.
    logic wdt_pend;                        // Overflow pending.
    logic nmi_step;                        // One non-maskable instruction owed.
    sb_state_t sb;                         // Standby state.
    logic irq_o;                           // Registered watchdog interrupt.
    logic nmi_o;                           // Registered non-maskable request.
  } wsc_state_t;

  wsc_state_t st_r;                        // Current state.
  wsc_state_t st_nxt;                      // Next state.
  logic tick;                              // Count clock tick.
  logic unmasked;                          // Unmasked vectored request pending.
  logic macro_pend;                        // Unmasked request set for macro service.
  logic [7:0] mwr;                         // Masked write value.
  logic ovf;                               // Watchdog count wraps on this tick.

  ////////////////////////////////////////////////////////////////////////////
  // The divider runs free of the watchdog clear.
  prescaler u_pre (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .sel(st_r.mode[MODE_DIV_HI:MODE_DIV_LO]),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for watchdog, priority and standby.
  always_comb begin
    st_nxt = st_r;
    // Requests picked for macro service do not block halt; they only delay it.
    unmasked = |(irq_flag & ~irq_mask & ~irq_svc_sel);
    macro_pend = |(irq_flag & ~irq_mask & irq_svc_sel);
    mwr = wdata & MODE_WMASK;
    ovf = 1'b0;
    // Count advances only while running.
    // The wrap itself is latched after the arbitration below.
    if (st_r.mode[MODE_RUN_BIT] && tick) begin
      st_nxt.cnt = st_r.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      ovf = &st_r.cnt;
    end
    // Only the immediate store reaches the mode register.
    if (mode_imm_we) begin
      st_nxt.mode = mwr;
      st_nxt.mode[MODE_RUN_BIT] = st_r.mode[MODE_RUN_BIT] | mwr[MODE_RUN_BIT];
      if (mwr[MODE_RUN_BIT]) begin
        st_nxt.cnt = '0;
      end
    end
    // Priority arbitration of watchdog against non-maskable.
    st_nxt.irq_o = 1'b0;
    st_nxt.nmi_o = 1'b0;
    if (st_r.nmi_step) begin
      // One non-maskable instruction runs, then the watchdog vectors.
      st_nxt.nmi_o = 1'b1;
      if (insn_done) begin
        st_nxt.nmi_step = 1'b0;
        st_nxt.irq_o = 1'b1;
        st_nxt.wdt_pend = 1'b0;
      end
    end else if (st_r.wdt_pend && nmi_req && st_r.mode[MODE_PRIO_BIT]) begin
      // Both pending with the priority bit set: one non-maskable instruction is owed.
      st_nxt.nmi_step = 1'b1;
      st_nxt.nmi_o = 1'b1;
    end else if (nmi_req) begin
      st_nxt.nmi_o = 1'b1;
    end else if (st_r.wdt_pend) begin
      st_nxt.irq_o = 1'b1;
      st_nxt.wdt_pend = 1'b0;
    end
    // A wrap in the cycle that hands out the previous request must not be lost,
    // so the set is applied after the clear above and wins over it.
    if (ovf) begin
      st_nxt.wdt_pend = 1'b1;
    end
    // Standby control writes and entry.
    if (standby_control_we) begin
      st_nxt.origin = wdata[SBY_ORIGIN_BIT];
      if (wdata[SBY_STOP_BIT]) begin
        st_nxt.sb = SB_STOP;
      end else if (wdata[SBY_HALT_BIT] && !unmasked) begin
        st_nxt.sb = (macro_pend || macro_busy) ? SB_WAIT : SB_HALT;
      end
    end
    case (st_r.sb)
      SB_RUN: begin
      end
      SB_WAIT: begin
        if (!macro_busy) begin
          st_nxt.sb = SB_HALT;
        end
      end
      SB_HALT, SB_STOP: begin
        // The origin flag keeps what software wrote, so a release reads back
        // as one while a reset reads back as zero.
        if (wake) begin
          st_nxt.sb = SB_RUN;
        end
      end
      default: st_nxt.sb = SB_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers all state.
  // Reset loads constants only, so the origin flag reads zero after it.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{mode: MODE_RESET, origin: 1'b0, cnt: '0, wdt_pend: 1'b0,
                nmi_step: 1'b0, sb: SB_RUN, irq_o: 1'b0, nmi_o: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Register and status outputs.
  // The low three bits of the standby readback mirror origin, stop and halt.
  assign watchdog_mode = st_r.mode;
  assign standby_control = {5'h00, st_r.origin, st_r.sb == SB_STOP, st_r.sb == SB_HALT};
  assign watchdog_interrupt = st_r.irq_o;
  assign nmi_take = st_r.nmi_o;
  assign halted = (st_r.sb == SB_HALT);
  assign stopped = (st_r.sb == SB_STOP);

  ////////////////////////////////////////////////////////////////////////////
  // Checks beside the logic.
  // Each one is disabled while reset is low, so a reset in mid-run is quiet.
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (watchdog_mode & ~MODE_WMASK) == 8'h00) else $error("reserved mode bits set");
  run_sticky_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    watchdog_mode[MODE_RUN_BIT] |=> watchdog_mode[MODE_RUN_BIT])
    else $error("run bit cleared");
  plain_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (mode_plain_we && !mode_imm_we) |=> $stable(watchdog_mode))
    else $error("ordinary write changed mode");
  mode_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !mode_imm_we |=> $stable(watchdog_mode))
    else $error("mode changed without immediate store");
  halt_refused_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (standby_control_we && wdata[SBY_HALT_BIT] && !wdata[SBY_STOP_BIT] && unmasked && !halted
     && st_r.sb == SB_RUN) |=> !halted) else $error("halt entered with pending request");
  halt_entry_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (standby_control_we && wdata[SBY_HALT_BIT] && !wdata[SBY_STOP_BIT] && !unmasked && !macro_pend
     && !macro_busy && st_r.sb == SB_RUN) |=> halted) else $error("halt not entered");
  macro_first_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r.sb == SB_WAIT && macro_busy) |=> !halted)
    else $error("halt before macro service end");
  wait_halt_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r.sb == SB_WAIT && !macro_busy && !standby_control_we) |=> halted)
    else $error("halt not entered after macro service");
  count_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (mode_imm_we && wdata[MODE_RUN_BIT]) |=> st_r.cnt == '0)
    else $error("count not cleared");
  prio_first_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r.wdt_pend && nmi_req && st_r.mode[MODE_PRIO_BIT] && !st_r.nmi_step)
    |=> (nmi_take && !watchdog_interrupt)) else $error("non-maskable step skipped");
  prio_step_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r.nmi_step && insn_done) |=> watchdog_interrupt)
    else $error("watchdog not vectored after one instruction");
  overflow_irq_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r.wdt_pend && !nmi_req && !st_r.nmi_step) |=> watchdog_interrupt)
    else $error("overflow lost");
  origin_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !standby_control_we |=> $stable(standby_control[SBY_ORIGIN_BIT]))
    else $error("origin flag changed without a write");
  wake_release_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ((halted || stopped) && wake && !standby_control_we) |=> (!halted && !stopped))
    else $error("standby not released");
endmodule

// ==== verification/watchdog_standby_control_tb.sv ====
// Self-checking bench for the watchdog and standby control block.
// Assumes wdt_pkg is compiled first and count clock select 0 is the fastest tick.
`timescale 1ns/1ps
module watchdog_standby_control_tb;
  import wdt_pkg::*;
  typedef struct packed {logic [2:0] sel; logic [7:0] val;} note_t; // One expected result.
  logic ref_clk = 1'b0; // 200 MHz clock.
  logic nrst = 1'b0; // Reset, active low.
  logic mode_imm_we = 1'b0, mode_plain_we = 1'b0, standby_control_we = 1'b0; // Write strobes.
  logic macro_busy = 1'b0, nmi_req = 1'b0, insn_done = 1'b0, wake = 1'b0; // CPU events.
  logic [7:0] wdata = 8'h00; // Write data.
  logic [IRQ_N-1:0] irq_flag = '0, irq_mask = '0, irq_svc_sel = '0; // Interrupt state.
  logic [7:0] watchdog_mode, standby_control; // Readbacks.
  logic watchdog_interrupt, nmi_take, halted, stopped; // Status outputs.
  int err_count = 0, cmp_count = 0, wdi_cnt = 0, base, i; // Counters.
  logic done_prev = 1'b0; // Instruction-done seen at the last edge.
  logic [7:0] d; // Random write value.
  note_t exp_q[$]; // Expected results, oldest first.
  event chk_ev; // Fires when results are settled.
  ////////////////////////////////////////////////////////////////////////////////
  // Device under test.
  watchdog_standby_control u_watchdog_standby_control (.ref_clk(ref_clk), .nrst(nrst),
    .mode_imm_we(mode_imm_we), .mode_plain_we(mode_plain_we), .wdata(wdata),
    .standby_control_we(standby_control_we), .irq_flag(irq_flag), .irq_mask(irq_mask), .irq_svc_sel(irq_svc_sel),
    .macro_busy(macro_busy), .nmi_req(nmi_req), .insn_done(insn_done), .wake(wake),
    .watchdog_mode(watchdog_mode), .standby_control(standby_control),
    .watchdog_interrupt(watchdog_interrupt), .nmi_take(nmi_take), .halted(halted),
    .stopped(stopped));
  // Clock generator, 2.5 ns half period.
  always #2.5 ref_clk = ~ref_clk;
  // Counts interrupt pulses and remembers the instruction-done strobe.
  always @(posedge ref_clk) begin
    if (watchdog_interrupt === 1'b1) wdi_cnt <= wdi_cnt + 1;
    done_prev <= insn_done;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Picks the observed value that a note refers to.
  function automatic logic [7:0] observe(input logic [2:0] s);
    case (s)
      3'h0: return watchdog_mode;
      3'h1: return standby_control;
      3'h2: return {7'h00, watchdog_interrupt};
      3'h3: return {7'h00, nmi_take};
      3'h4: return {7'h00, halted};
      3'h5: return {7'h00, stopped};
      3'h6: return 8'(wdi_cnt);
      default: return {7'h00, done_prev};
    endcase
  endfunction
  // Compares one seen value with its expectation.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Monitor: takes every queued note, oldest first, whenever results are presented.
  always @(chk_ev) begin
    note_t n;
    while (exp_q.size() > 0) begin
      n = exp_q.pop_front();
      check(observe(n.sel), n.val);
    end
  end
  // Records an expectation and hands it to the monitor.
  task automatic note_exp(input logic [2:0] s, input logic [7:0] v);
    exp_q.push_back('{s, v});
    ->chk_ev;
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Bus helpers: drive on the falling edge, one-cycle strobes.
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr_mode(input logic [7:0] v, input logic imm);
    @(negedge ref_clk);
    wdata = v;
    mode_imm_we = imm;
    mode_plain_we = ~imm;
    @(negedge ref_clk);
    mode_imm_we = 1'b0;
    mode_plain_we = 1'b0;
  endtask
  task automatic wr_standby_control(input logic [7:0] v);
    @(negedge ref_clk);
    wdata = v;
    standby_control_we = 1'b1;
    @(negedge ref_clk);
    standby_control_we = 1'b0;
  endtask
  // Bounded wait for a status bit; running out ends the run as a failure.
  task automatic wait_hi(input logic [2:0] s, input int bound);
    int k;
    logic [7:0] o;
    for (k = 0; k < bound; k++) begin
      o = observe(s);
      if (o[0] === 1'b1) break;
      @(negedge ref_clk);
    end
    if (k == bound) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, 8'h00, 8'h01);
      final_report();
    end
  endtask
  // Standby release pulse.
  task automatic pulse_wake();
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    void'($urandom(32'hbd50));
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) nrst = 1'b1;
    cyc(1);
    note_exp(3'h0, MODE_RESET);
    note_exp(3'h1, SBY_RESET);
    wr_mode(8'hff, 1'b0);
    note_exp(3'h0, 8'h00);
    for (i = 0; i < 6; i++) begin
      d = 8'($urandom) & 8'h77; // Run clear, bit 3 written as zero.
      wr_mode(d, 1'b1);
      note_exp(3'h0, d & MODE_WMASK);
    end
    $display("test mode writes done");
    wr_mode(8'h90, 1'b1); // Priority chosen once, with the start.
    wr_mode(8'h10, 1'b1);
    note_exp(3'h0, 8'h90);
    base = wdi_cnt;
    repeat (40) begin
      cyc(150);
      wr_mode(8'h90, 1'b1); // Clearing well before 256 ticks keeps it quiet.
    end
    note_exp(3'h6, 8'(base));
    wait_hi(3'h2, 40000);
    $display("test overflow done");
    wr_mode(8'h90, 1'b1);
    note_exp(3'h0, 8'h90);
    nmi_req = 1'b1;
    for (i = 0; i < 40000; i++) begin
      insn_done = (i % 16 == 15); // First handler instruction is a no-op.
      @(negedge ref_clk);
      if (watchdog_interrupt === 1'b1) break;
    end
    insn_done = 1'b0;
    note_exp(3'h7, 8'h01);
    note_exp(3'h3, 8'h01);
    nmi_req = 1'b0;
    if (i == 40000) begin
      err_count++;
      final_report();
    end
    $display("test priority done");
    wr_standby_control(8'h04);
    note_exp(3'h1, 8'h04);
    irq_flag = 8'h01;
    wr_standby_control(8'h05);
    cyc(2);
    note_exp(3'h4, 8'h00);
    irq_mask = 8'h01;
    wr_standby_control(8'h05);
    note_exp(3'h4, 8'h01);
    pulse_wake();
    note_exp(3'h1, 8'h04);
    irq_flag = 8'h02;
    irq_svc_sel = 8'h02;
    macro_busy = 1'b1;
    wr_standby_control(8'h05);
    cyc(3);
    note_exp(3'h4, 8'h00);
    macro_busy = 1'b0;
    irq_flag = 8'h00;
    wait_hi(3'h4, 4);
    pulse_wake();
    wr_standby_control(8'h06); // The bench clock stands for the own oscillator.
    note_exp(3'h5, 8'h01);
    pulse_wake();
    note_exp(3'h5, 8'h00);
    note_exp(3'h1, 8'h04);
    $display("test standby done");
    // A second reset in mid-run must read back as a power-on origin.
    @(negedge ref_clk) nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    cyc(1);
    note_exp(3'h0, MODE_RESET);
    note_exp(3'h1, SBY_RESET);
    $display("test reset done");
    cyc(2);
    final_report();
  end
endmodule
